// ===== rtl/aso_ctrl.sv
// converter sequencer, oversampler, result store and axi4-lite regs
// assumes analog core on aclk; sample valid when conversion time ends
// Summary of operation
// RULE1 - conversion lasts per-channel sampling time plus 12.5 cycles
// RULE2 - no sequencing: one channel, ordinary slot one or preempted slot four
// RULE3 - sequence mode: whole group; preempted starts at slot 4 minus length
// RULE4 - auto mode starts preempted group when ordinary group ends
// RULE5 - repeat mode keeps converting; with auto alternates both groups
// RULE6 - ordinary partition converts next subgroup of programmed size per trigger
// RULE7 - preempted partition converts next single slot per trigger
// RULE8 - software never combines partition with repeat mode
// RULE9 - oversample: convert ratio times, sum, shift right with rounding
// RULE10 - oversampled result keeps only its low 16 bits
// RULE11 - oversampling ignores alignment and offsets, right aligned
// RULE12 - resume bit 0 keeps sum after preemption, 1 restarts it
// RULE13 - trigger mode needs a trigger per conversion and after preemption
// RULE14 - ordinary and preempted oversampling enabled independently
// RULE15 - ordinary result in one register, preempted results per slot
// RULE16 - 12-bit result right or left aligned in a 16-bit word
// RULE17 - preempted offset subtracted, negative sign-extended upward
// RULE18 - dma request on every ordinary result update when enabled
// RULE19 - monitor sets out-of-range flag, all or one selected channel
// RULE20 - compare raw 12-bit value, or 16-bit oversampled value
// RULE21 - five status flags; both end flags and the out-of-range flag raise interrupt when enabled
// RULE22 - subgroup code 000 means one channel up to 111 meaning eight
// RULE23 - ordinary end flag clears on written 0 or result read
// RULE24 - in sequence mode end flags set only after last channel
// RULE25 - preempted trigger suspends ordinary; ordinary trigger waits
// RULE26 - one sample per conversion; next channel only after sample
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`include "aso_regs.svh"
module aso_ctrl
  import aso_pkg::*;
(
  input wire logic aclk, // clock, 100 mhz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic ord_trigger_in, // ordinary trigger pin
  input wire logic pre_trigger_in, // preempted trigger pin
  input wire logic [11:0] core_sample, // sample from analog core
  output logic conv_start, // one-cycle start to the core
  output logic [4:0] conv_channel, // channel being converted
  output logic irq, // interrupt, level
  output logic dma_req // one-cycle dma request
);
  aso_st_t s_r, s_nxt;
  logic abort, take, os, fin, ofin, ogdone, mon_en, oor_w;
  logic [19:0] acc_in;
  logic [7:0] sn, last_m1;
  logic [1:0] pstart;
  logic [15:0] word;

  // merge write data into the old word by byte enables
  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] n, input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[8*i+:8] = n[8*i+:8];
    return r;
  endfunction

  // read decode, bit 32 marks an unmapped address
  function automatic logic [32:0] rd(input aso_st_t s,
    input logic [11:0] a);
    logic [32:0] r;
    r = 33'h0;
    case (a)
      `ASO_STS: r[4:0] = s.sts;
      `ASO_CTRL1: r[31:0] = s.c1;
      `ASO_CTRL2: r[31:0] = s.c2;
      `ASO_OVSP: r[31:0] = s.ov;
      `ASO_HB: r[15:0] = s.hb;
      `ASO_LB: r[15:0] = s.lb;
      `ASO_ODT: r[15:0] = s.odt;
      `ASO_OSQ1: for (int i = 0; i < 6; i++) r[5*i+:5] = s.osq[i];
      `ASO_OSQ2: for (int i = 0; i < 6; i++) r[5*i+:5] = s.osq[6+i];
      `ASO_OSQ3:
      begin
        for (int i = 0; i < 4; i++)
          r[5*i+:5] = s.osq[12+i];
        r[23:20] = s.olen;
      end
      `ASO_PSQ:
      begin
        for (int i = 0; i < 4; i++)
          r[5*i+:5] = s.psq[i];
        r[21:20] = s.plen;
      end
      default: r[32] = 1'h1;
    endcase
    for (int i = 0; i < 4; i++)
    begin
      if (a == `ASO_OFS + 12'(4*i))
        r = {21'h0, s.ofs[i]};
      if (a == `ASO_PDT + 12'(4*i))
        r = {17'h0, s.pdt[i]};
    end
    if (a[11:8] == 4'h1 && a[7:2] < `ASO_NCH && a[1:0] == 2'h0)
      r = {25'h0, s.spt[a[6:2]]};
    return r;
  endfunction

  // cycles minus one for a channel: (half + 25) / 2 rounded up
  function automatic logic [7:0] cyc(input aso_st_t s,
    input logic [4:0] c);
    logic [8:0] t;
    t = 9'(s.spt[(c > 5'd17) ? 5'd0 : c]) + `ASO_FIX_HALF - 9'd1;
    return t[8:1]; // RULE1
  endfunction

  // datapath of the conversion being finished
  assign abort = s_r.state == ASO_CONV && !s_r.pre &&
    s_r.c2[`ASO_C2_PSW]; // RULE25
  assign take = s_r.state == ASO_CONV && s_r.cnt == 8'h0 &&
    !abort; // RULE26
  assign os = s_r.pre ? s_r.ov[`ASO_OV_POS] :
    s_r.ov[`ASO_OV_OOS]; // RULE14
  assign acc_in = (s_r.pre ? s_r.pacc : s_r.oacc) +
    {8'h0, core_sample};
  assign sn = s_r.pre ? s_r.psn : s_r.osn;
  assign last_m1 = (8'h2 << s_r.ov[4:2]) - 8'h1;
  assign fin = take && (!os || sn == last_m1); // RULE9
  assign ofin = fin && !s_r.pre;
  assign ogdone = ofin && s_r.oleft == 4'h0;
  assign pstart = (s_r.c1[`ASO_C1_SEQ] || s_r.c1[`ASO_C1_PPART]) ?
    2'd3 - s_r.plen : 2'd3; // RULE2 RULE3
  assign mon_en = (s_r.pre ? s_r.c1[`ASO_C1_PMON] :
    s_r.c1[`ASO_C1_OMON]) && (!s_r.c1[`ASO_C1_SGL] ||
    s_r.ch == s_r.c1[4:0]); // RULE19

  aso_fmt u_fmt (
    .sample(core_sample),
    .acc(acc_in),
    .os(os),
    .shift(s_r.ov[8:5]),
    .left(s_r.c2[`ASO_C2_ALIGN]),
    .pre(s_r.pre),
    .offset(s_r.ofs[s_r.pidx]),
    .hb(s_r.hb),
    .lb(s_r.lb),
    .word(word),
    .oor(oor_w)
  );

  // next state: bus first, hardware sets after so sets win
  always_comb
  begin
    logic [31:0] wv;
    logic [32:0] rv;
    logic [3:0] nx;
    wv = 32'h0;
    rv = 33'h0;
    nx = 4'h0;
    s_nxt = s_r;
    s_nxt.cs = 1'h0;
    s_nxt.dma = 1'h0;
    s_nxt.sy = {s_r.sy[1:0], ord_trigger_in, pre_trigger_in};
    s_nxt.tp = s_r.sy[3:2];
    if (s_r.awr && s_axi_awvalid)
    begin
      s_nxt.awok = 1'h1;
      s_nxt.awa = s_axi_awaddr;
    end
    if (s_r.wr && s_axi_wvalid)
    begin
      s_nxt.wok = 1'h1;
      s_nxt.wd = s_axi_wdata;
      s_nxt.ws = s_axi_wstrb;
    end
    if (s_r.bv && s_axi_bready)
      s_nxt.bv = 1'h0;
    if (s_r.awok && s_r.wok && !s_r.bv)
    begin
      rv = rd(s_r, s_r.awa);
      wv = merge(rv[31:0], s_r.wd, s_r.ws);
      s_nxt.bv = 1'h1;
      s_nxt.br = rv[32] ? `ASO_SLVERR : `ASO_OKAY;
      s_nxt.awok = 1'h0;
      s_nxt.wok = 1'h0;
      case (s_r.awa)
        `ASO_STS: s_nxt.sts = s_r.sts & wv[4:0]; // RULE23
        `ASO_CTRL1: s_nxt.c1 = wv & `ASO_C1_MASK;
        `ASO_CTRL2: s_nxt.c2 = wv & `ASO_C2_MASK;
        `ASO_OVSP: s_nxt.ov = wv & `ASO_OV_MASK;
        `ASO_HB: s_nxt.hb = wv[15:0];
        `ASO_LB: s_nxt.lb = wv[15:0];
        `ASO_OSQ1: for (int i = 0; i < 6; i++) s_nxt.osq[i] = wv[5*i+:5];
        `ASO_OSQ2: for (int i = 0; i < 6; i++) s_nxt.osq[6+i] = wv[5*i+:5];
        `ASO_OSQ3:
        begin
          for (int i = 0; i < 4; i++)
            s_nxt.osq[12+i] = wv[5*i+:5];
          s_nxt.olen = wv[23:20];
        end
        `ASO_PSQ:
        begin
          for (int i = 0; i < 4; i++)
            s_nxt.psq[i] = wv[5*i+:5];
          s_nxt.plen = wv[21:20];
        end
        default: ;
      endcase
      for (int i = 0; i < 4; i++)
        if (s_r.awa == `ASO_OFS + 12'(4*i))
          s_nxt.ofs[i] = wv[11:0];
      if (s_r.awa[11:8] == 4'h1 && s_r.awa[7:2] < `ASO_NCH &&
        s_r.awa[1:0] == 2'h0)
        s_nxt.spt[s_r.awa[6:2]] = wv[7:0];
    end
    if (s_r.rv && s_axi_rready)
      s_nxt.rv = 1'h0;
    if (s_r.arr && s_axi_arvalid)
    begin
      rv = rd(s_r, s_axi_araddr);
      s_nxt.rv = 1'h1;
      s_nxt.rd = rv[31:0];
      s_nxt.rr = rv[32] ? `ASO_SLVERR : `ASO_OKAY;
      if (s_axi_araddr == `ASO_ODT)
        s_nxt.sts[`ASO_S_OCE] = 1'h0; // RULE23
    end
    s_nxt.awr = !s_nxt.awok;
    s_nxt.wr = !s_nxt.wok;
    s_nxt.arr = !s_nxt.rv;
    // sequencer
    case (s_r.state)
      ASO_IDLE:
      begin
        if (s_r.c2[`ASO_C2_PSW] && !s_r.pact)
        begin
          s_nxt.pact = 1'h1;
          s_nxt.c2[`ASO_C2_PSW] = 1'h0;
          s_nxt.sts[`ASO_S_PCS] = 1'h1;
          s_nxt.pidx = (s_r.c1[`ASO_C1_PPART] && s_r.pnext >= pstart) ?
            s_r.pnext : pstart; // RULE3 RULE7
          s_nxt.pacc = 20'h0;
          s_nxt.psn = 8'h0;
        end
        else if (s_r.c2[`ASO_C2_OSW] && !s_r.oact)
        begin
          s_nxt.oact = 1'h1;
          s_nxt.owait = 1'h0;
          s_nxt.c2[`ASO_C2_OSW] = 1'h0;
          s_nxt.sts[`ASO_S_OCS] = 1'h1;
          s_nxt.oidx = s_r.c1[`ASO_C1_OPART] ? s_r.onext : 4'h0; // RULE6
          s_nxt.oleft = s_r.c1[`ASO_C1_OPART] ? {1'h0, s_r.c1[15:13]} :
            (s_r.c1[`ASO_C1_SEQ] ? s_r.olen : 4'h0); // RULE22 RULE2
          s_nxt.oacc = 20'h0;
          s_nxt.osn = 8'h0;
        end
        else if (s_r.c2[`ASO_C2_OSW] && s_r.owait)
        begin
          s_nxt.owait = 1'h0; // RULE13
          s_nxt.c2[`ASO_C2_OSW] = 1'h0;
        end
        else if (s_r.pact || (s_r.oact && !s_r.owait))
        begin
          // preempted group always goes first
          s_nxt.pre = s_r.pact; // RULE25
          s_nxt.ch = s_r.pact ? s_r.psq[s_r.pidx] : s_r.osq[s_r.oidx];
          s_nxt.cnt = cyc(s_r, s_nxt.ch); // RULE1
          s_nxt.cs = 1'h1;
          s_nxt.state = ASO_CONV;
        end
      end
      ASO_CONV:
      begin
        s_nxt.cnt = s_r.cnt - 8'h1;
        if (abort)
        begin
          s_nxt.state = ASO_IDLE; // RULE25
          if (s_r.ov[`ASO_OV_OOS] && s_r.ov[`ASO_OV_ORES])
          begin
            s_nxt.oacc = 20'h0; // RULE12
            s_nxt.osn = 8'h0;
          end
          if (s_r.ov[`ASO_OV_OTRG])
            s_nxt.owait = 1'h1; // RULE13
        end
        else if (take && s_r.pre)
        begin
          s_nxt.state = ASO_IDLE;
          s_nxt.pacc = acc_in;
          s_nxt.psn = s_r.psn + 8'h1;
          if (fin)
          begin
            s_nxt.pdt[s_r.pidx] = word; // RULE15
            s_nxt.pacc = 20'h0;
            s_nxt.psn = 8'h0;
            if (mon_en && oor_w)
              s_nxt.sts[`ASO_S_OOR] = 1'h1; // RULE19
            if (s_r.pidx == 2'd3 || s_r.c1[`ASO_C1_PPART])
            begin
              s_nxt.pact = 1'h0;
              s_nxt.sts[`ASO_S_PCE] = 1'h1; // RULE24
              s_nxt.pnext = (s_r.pidx == 2'd3) ? pstart :
                s_r.pidx + 2'd1; // RULE7
            end
            else
              s_nxt.pidx = s_r.pidx + 2'd1; // RULE3
          end
        end
        else if (take)
        begin
          s_nxt.state = ASO_IDLE;
          s_nxt.oacc = acc_in;
          s_nxt.osn = s_r.osn + 8'h1;
          if (s_r.ov[`ASO_OV_OTRG])
            s_nxt.owait = 1'h1; // RULE13
          if (fin)
          begin
            s_nxt.odt = word; // RULE15
            s_nxt.dma = s_r.c2[`ASO_C2_DMA]; // RULE18
            s_nxt.oacc = 20'h0;
            s_nxt.osn = 8'h0;
            if (mon_en && oor_w)
              s_nxt.sts[`ASO_S_OOR] = 1'h1; // RULE19
            nx = (s_r.oidx == s_r.olen) ? 4'h0 : s_r.oidx + 4'h1;
            if (s_r.oleft == 4'h0)
            begin
              s_nxt.oact = 1'h0;
              s_nxt.owait = 1'h0;
              s_nxt.sts[`ASO_S_OCE] = 1'h1; // RULE24
              s_nxt.onext = nx; // RULE6
              if (s_r.c1[`ASO_C1_AUTO])
                s_nxt.c2[`ASO_C2_PSW] = 1'h1; // RULE4
              if (s_r.c2[`ASO_C2_RPT])
                s_nxt.c2[`ASO_C2_OSW] = 1'h1; // RULE5
            end
            else
            begin
              s_nxt.oleft = s_r.oleft - 4'h1;
              s_nxt.oidx = nx; // RULE3
            end
          end
        end
      end
      default: s_nxt.state = ASO_IDLE;
    endcase
    // pin edges set pending bits last, so a new edge beats a group start
    if (s_r.sy[3] && !s_r.tp[1])
      s_nxt.c2[`ASO_C2_OSW] = 1'h1;
    if (s_r.sy[2] && !s_r.tp[0])
      s_nxt.c2[`ASO_C2_PSW] = 1'h1;
    // interrupt from the two end flags, the out-of-range flag and their enables
    s_nxt.irq = |(s_nxt.sts[2:0] & {s_nxt.c1[`ASO_C1_PCEIE],
      s_nxt.c1[`ASO_C1_OCEIE], s_nxt.c1[`ASO_C1_OORIE]}); // RULE21
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r <= '0;
      s_r.hb <= `ASO_HB_RST;
    end
    else
      s_r <= s_nxt;
  end

  // outputs
  assign s_axi_awready = s_r.awr;
  assign s_axi_wready = s_r.wr;
  assign s_axi_bvalid = s_r.bv;
  assign s_axi_bresp = s_r.br;
  assign s_axi_arready = s_r.arr;
  assign s_axi_rvalid = s_r.rv;
  assign s_axi_rdata = s_r.rd;
  assign s_axi_rresp = s_r.rr;
  assign conv_start = s_r.cs;
  assign conv_channel = s_r.ch;
  assign irq = s_r.irq;
  assign dma_req = s_r.dma;

  // checks on sequencing and flags
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_pre_launch;
    s_r.cs && s_r.pre;
  endsequence
  sequence s_ord_launch;
    s_r.cs && !s_r.pre;
  endsequence
  conv_time_a: assert property (s_pre_launch ##0 s_r.cnt == 8'd12
    |-> ##12 take) else $error("conversion time wrong"); // RULE1
  pre_slot4_a: assert property (s_pre_launch ##0
    (!s_r.c1[8] && !s_r.c1[12]) |-> s_r.ch == s_r.psq[3])
    else $error("single preempted slot wrong"); // RULE2
  pre_seq_start_a: assert property ($rose(s_r.pact) && s_r.c1[8] &&
    !s_r.c1[12] |-> s_r.pidx == 2'd3 - s_r.plen)
    else $error("preempted start slot wrong"); // RULE3
  auto_pre_a: assert property (ogdone && s_r.c1[10] |=>
    s_r.c2[21] || s_r.pact) else $error("no auto preempt"); // RULE4
  repeat_a: assert property (ogdone && s_r.c2[1] |=> s_r.c2[22])
    else $error("repeat not rearmed"); // RULE5
  ppart_one_a: assert property (fin && s_r.pre && s_r.c1[12] |=>
    !s_r.pact) else $error("preempted partition overran"); // RULE7
  preempt_a: assert property (abort |=> s_r.state == ASO_IDLE ##2
    s_pre_launch) else $error("preemption not served"); // RULE25
  trig_wait_a: assert property (s_r.owait && !s_r.c2[22] |=>
    !(s_r.cs && !s_r.pre)) else $error("ran without trigger"); // RULE13
  dma_req_a: assert property (s_r.dma |-> $past(ofin) &&
    $past(s_r.c2[8])) else $error("stray dma request"); // RULE18
  odt_clear_a: assert property (s_axi_arvalid && s_r.arr &&
    s_axi_araddr == 12'h04c && !ogdone |=> !s_r.sts[1])
    else $error("result read kept end flag"); // RULE23
  oor_set_a: assert property (fin && mon_en && oor_w |=> s_r.sts[0])
    else $error("window miss not flagged"); // RULE19
  irq_end_a: assert property (s_r.sts[1] && s_r.c1[5] |-> s_r.irq)
    else $error("end interrupt missing"); // RULE21
  ord_single_a: assert property (s_ord_launch ##0 !s_r.c1[8] &&
    !s_r.c1[11] |-> s_r.ch == s_r.osq[0])
    else $error("single ordinary slot wrong"); // RULE2
endmodule

// ===== rtl/aso_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes byte addresses on a 32-bit axi4-lite slave, word access
`ifndef ASO_REGS_SVH
`define ASO_REGS_SVH
// word offsets
`define ASO_STS 12'h000
`define ASO_CTRL1 12'h004
`define ASO_CTRL2 12'h008
`define ASO_OFS 12'h014
`define ASO_HB 12'h024
`define ASO_LB 12'h028
`define ASO_OSQ1 12'h02c
`define ASO_OSQ2 12'h030
`define ASO_OSQ3 12'h034
`define ASO_PSQ 12'h038
`define ASO_PDT 12'h03c
`define ASO_ODT 12'h04c
`define ASO_OVSP 12'h080
`define ASO_SPT 12'h100
`define ASO_NCH 6'h12
// writable masks and reset values
`define ASO_C1_MASK 32'h00c0ffff
`define ASO_C2_MASK 32'h00600902
`define ASO_OV_MASK 32'h000007ff
`define ASO_HB_RST 16'hffff
// status bits
`define ASO_S_OCS 4
`define ASO_S_PCS 3
`define ASO_S_PCE 2
`define ASO_S_OCE 1
`define ASO_S_OOR 0
// control 1 bits
`define ASO_C1_OMON 23
`define ASO_C1_PMON 22
`define ASO_C1_PPART 12
`define ASO_C1_OPART 11
`define ASO_C1_AUTO 10
`define ASO_C1_SGL 9
`define ASO_C1_SEQ 8
`define ASO_C1_PCEIE 7
`define ASO_C1_OORIE 6
`define ASO_C1_OCEIE 5
// control 2 bits
`define ASO_C2_OSW 22
`define ASO_C2_PSW 21
`define ASO_C2_ALIGN 11
`define ASO_C2_DMA 8
`define ASO_C2_RPT 1
// oversampling control bits
`define ASO_OV_OOS 0
`define ASO_OV_POS 1
`define ASO_OV_OTRG 9
`define ASO_OV_ORES 10
// fixed conversion part, 12.5 cycles counted in half cycles
`define ASO_FIX_HALF 9'd25
// bus responses
`define ASO_OKAY 2'b00
`define ASO_SLVERR 2'b10
`endif

// ===== rtl/aso_pkg.sv
// types of the converter sequencing and oversampling control
// assumes aso_regs.svh for all numeric constants
package aso_pkg;
  typedef enum logic {ASO_IDLE, ASO_CONV} aso_state_t;
  typedef struct packed {
    aso_state_t state;
    logic [7:0] cnt;
    logic pre;
    logic oact, owait;
    logic [3:0] oidx, oleft, onext;
    logic [19:0] oacc;
    logic [7:0] osn;
    logic pact;
    logic [1:0] pidx, pnext;
    logic [19:0] pacc;
    logic [7:0] psn;
    logic [3:0] sy;
    logic [1:0] tp;
    logic [4:0] sts;
    logic [31:0] c1, c2, ov;
    logic [3:0][11:0] ofs;
    logic [15:0] hb, lb, odt;
    logic [15:0][4:0] osq;
    logic [3:0] olen;
    logic [3:0][4:0] psq;
    logic [1:0] plen;
    logic [3:0][15:0] pdt;
    logic [17:0][7:0] spt;
    logic awok, wok, awr, wr, bv, arr, rv;
    logic [11:0] awa;
    logic [31:0] wd, rd;
    logic [3:0] ws;
    logic [1:0] br, rr;
    logic cs, irq, dma;
    logic [4:0] ch;
  } aso_st_t;
endpackage

// ===== rtl/aso_fmt.sv
// result formatting and window comparison, purely combinational
// assumes acc already holds the running sum including sample
module aso_fmt
  import aso_pkg::*;
(
  input wire logic [11:0] sample, // raw converter sample
  input wire logic [19:0] acc, // running sum with this sample
  input wire logic os, // oversampling active for group
  input wire logic [3:0] shift, // right shift 0 to 8
  input wire logic left, // left alignment selected
  input wire logic pre, // result belongs to preempted group
  input wire logic [11:0] offset, // offset of preempted slot
  input wire logic [15:0] hb, // monitor high bound
  input wire logic [15:0] lb, // monitor low bound
  output logic [15:0] word, // formatted 16-bit result
  output logic oor // value outside the window
);
  logic [20:0] rnd;
  logic [20:0] avg;
  logic [12:0] diff;

  // window test shared by both compare widths
  function automatic logic outside(input logic [15:0] v,
    input logic [15:0] h, input logic [15:0] l);
    return (v > h) || (v < l);
  endfunction

  // rounded right shift of the sum
  assign rnd = (shift == 4'h0) ? {1'h0, acc} :
    {1'h0, acc} + (21'h1 << (shift - 4'h1)); // RULE9
  assign avg = rnd >> shift; // RULE9
  // offset subtraction, sign kept in bit 12
  assign diff = {1'h0, sample} - {1'h0, offset}; // RULE17

  // alignment, offset and monitor selection
  always_comb
  begin
    if (os)
      word = avg[15:0]; // RULE10 RULE11
    else if (pre)
      word = left ? {diff, 3'h0} : {{3{diff[12]}}, diff}; // RULE17
    else
      word = left ? {sample, 4'h0} : {4'h0, sample}; // RULE16
    if (os)
      oor = outside(avg[15:0], hb, lb); // RULE20
    else
      oor = outside({4'h0, sample}, {4'h0, hb[11:0]},
        {4'h0, lb[11:0]}); // RULE20
  end
endmodule

// ===== sim/aso_core_model.sv
// behavioural analog core model for the converter sequencer
// assumes start pulses on aclk and a sample taken within HOLD cycles
module aso_core_model #(
  parameter int HOLD = 40 // cycles a sample stays valid after start
)
(
  input wire logic aclk, // clock
  input wire logic conv_start, // start of a conversion
  input wire logic [4:0] conv_channel, // channel to convert
  output logic [11:0] core_sample // sample to the sequencer
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] val = 12'h0;
  int age = 1000;
  // latch a channel-coded sample at each start
  always @(posedge aclk)
  begin
    if (conv_start === 1'b1)
    begin
      val <= {conv_channel, 7'h15};
      age <= 0;
    end
    else
      age <= age + 1;
  end
  // once the hold time is over the line shows a changing pattern
  assign core_sample = (age < HOLD) ? val : ~val ^ age[11:0];
endmodule

// ===== sim/tb.sv
// self-checking bench for the converter sequencer over axi4-lite
// assumes the core model answers with sample {channel, 7'h15}
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, opin = 1'h0, ppin = 1'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0, smp;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, cst, irq, dma;
  logic [1:0] bresp, rresp, r;
  logic [4:0] chan;
  logic [4:0] chq[$];
  int err_count = 0, check_count = 0, cyc = 0, dma_n = 0, t_st, t_dm;
  aso_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ord_trigger_in(opin),
    .pre_trigger_in(ppin), .core_sample(smp), .conv_start(cst),
    .conv_channel(chan), .irq(irq), .dma_req(dma));
  aso_core_model CORE (.aclk(aclk), .conv_start(cst),
    .conv_channel(chan), .core_sample(smp));
  initial forever #5 aclk = ~aclk;
  // cycle count, timeout, record of core starts and dma pulses
  always @(posedge aclk)
  begin
    cyc++;
    if (cst === 1'b1)
    begin
      chq.push_back(chan);
      t_st = cyc;
    end
    if (dma === 1'b1)
    begin
      dma_n++;
      t_dm = cyc;
    end
    if (cyc == 50000)
    begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] g, e, input string m);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
  // clear flags, write control 2 (maybe a trigger), poll a status bit
  task automatic go(input logic [31:0] c2, input int b);
    chq.delete();
    dma_n = 0;
    wr(12'h000, 32'h0);
    wr(12'h008, c2);
    do rd(12'h000); while (d[b] !== 1'b1);
  endtask
  task automatic cseq(input logic [4:0] e[$]);
    chk(chq.size(), e.size(), "conversion count");
    foreach (e[i]) chk(chq[i], e[i], "channel order");
  endtask
  task automatic pin(input bit pre);
    if (pre)
      ppin <= 1'b1;
    else
      opin <= 1'b1;
    repeat (4) @(posedge aclk);
    ppin <= 1'b0;
    opin <= 1'b0;
  endtask
  task automatic t_reset();
    rd(12'h024);
    chk(d, 32'hffff, "high bound reset");
    rd(12'h1f0);
    chk({d[29:0], r}, 32'h2, "unmapped read");
    wr(12'h1f0, 32'h1);
    chk(r, 2'h2, "unmapped write");
  endtask
  task automatic t_single();
    wr(12'h02c, 32'he5);
    wr(12'h004, 32'h20);
    go(32'h400100, 1);
    cseq('{5});
    chk(irq, 1'h1, "irq on end");
    rd(12'h04c);
    chk(d, 32'h295, "right aligned");
    chk(dma_n, 32'h1, "dma count");
    rd(12'h000);
    chk(d, 32'h10, "end cleared by read");
    chk(irq, 1'h0, "irq dropped");
  endtask
  task automatic t_time();
    int t0;
    go(32'h400100, 1);
    t0 = t_dm - t_st;
    wr(12'h114, 32'h7);
    go(32'h400100, 1);
    chk(t_dm - t_st - t0, 32'h3, "conversion time");
    wr(12'h114, 32'h0);
    go(32'h400800, 1);
    rd(12'h04c);
    chk(d, 32'h2950, "left aligned");
  endtask
  task automatic t_seq();
    wr(12'h02c, 32'h20c41);
    wr(12'h034, 32'h300000);
    wr(12'h038, 32'h14a000);
    wr(12'h004, 32'h520);
    go(32'h400100, 2);
    cseq('{1, 2, 3, 4, 8, 9});
    chk(dma_n, 32'h4, "dma per result");
    rd(12'h04c);
    chk(d, 32'h215, "last ordinary");
    rd(12'h044);
    chk(d, 32'h415, "preempted slot 3");
    rd(12'h048);
    chk(d, 32'h495, "preempted slot 4");
  endtask
  task automatic t_part();
    wr(12'h004, 32'h2800); // partition on, repeat left off
    wr(12'h008, 32'h0);
    go(32'h400000, 1);
    cseq('{1, 2});
    chq.delete();
    wr(12'h000, 32'h0);
    pin(1'b0);
    do rd(12'h000); while (d[1] !== 1'b1);
    cseq('{3, 4});
  endtask
  task automatic t_pre();
    wr(12'h004, 32'h0);
    wr(12'h020, 32'h600);
    wr(12'h000, 32'h0);
    chq.delete();
    pin(1'b1);
    do rd(12'h000); while (d[2] !== 1'b1);
    cseq('{9});
    rd(12'h048);
    chk(d, 32'hfe95, "negative offset result");
  endtask
  task automatic t_os();
    wr(12'h02c, 32'he5);
    wr(12'h080, 32'h25);
    go(32'h400800, 1);
    cseq('{5, 5, 5, 5});
    rd(12'h04c);
    chk(d, 32'h52a, "4x shift 1");
    wr(12'h024, 32'h9400);
    wr(12'h004, 32'h800000);
    wr(12'h080, 32'h1d);
    go(32'h400000, 1);
    rd(12'h04c);
    chk(d, 32'h9500, "256x truncated");
    rd(12'h000);
    chk(d, 32'h11, "16-bit bound");
    wr(12'h080, 32'h0);
    wr(12'h024, 32'h200);
    go(32'h400000, 1);
    rd(12'h000);
    chk(d, 32'h13, "raw above bound");
    wr(12'h004, 32'h800207);
    go(32'h400000, 1);
    rd(12'h000);
    chk(d, 32'h12, "other channel watched");
  endtask
  // repeat run, then preemption of ordinary oversampling, then partition
  task automatic t_abort();
    go(32'h400002, 1);
    wr(12'h008, 32'h0);
    rd(12'h04c);
    repeat (40) @(posedge aclk);
    cseq('{5, 5});
    wr(12'h080, 32'h3);
    wr(12'h004, 32'h1000);
    chq.delete();
    wr(12'h000, 32'h0);
    wr(12'h008, 32'h400000);
    pin(1'b1);
    do rd(12'h000); while (d[1] !== 1'b1);
    cseq('{5, 9, 9, 5, 5});
    rd(12'h04c);
    chk(d, 32'h52a, "resumed sum");
    rd(12'h048);
    chk(d, 32'h92a, "preempted oversampled");
    chq.delete();
    wr(12'h000, 32'h0);
    pin(1'b1);
    do rd(12'h000); while (d[2] !== 1'b1);
    cseq('{8, 8});
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_reset();
    t_single();
    t_time();
    t_seq();
    t_part();
    t_pre();
    t_os();
    t_abort();
    final_report();
  end
endmodule
